/* shared/ach_pkg.sv */
// Purpose: Constants and types for the card host pin controller
// Assumes: 25 MHz sys_clk, strobe timing counted in sys_clk cycles
// Notes:   Card side pins are active low where the name says so
package ach_pkg;
  // ==========================================================
  // Modes
  typedef enum logic [1:0] {
    ACH_MODE_MEM,
    ACH_MODE_IO,
    ACH_MODE_IDE
  } ach_mode_t;

  // ==========================================================
  // Host command kinds
  typedef enum logic [1:0] {
    ACH_CMD_READ,
    ACH_CMD_WRITE,
    ACH_CMD_ATTR_READ,
    ACH_CMD_ATTR_WRITE
  } ach_cmd_t;

  // ==========================================================
  // Widths and fields
  localparam int ACH_ADDR_W    = 11;
  localparam int ACH_IDE_ADDR_W = 3;
  localparam int ACH_DATA_W    = 16;
  localparam int ACH_EVEN_LSB  = 0;
  localparam int ACH_ODD_LSB   = 8;

  // ==========================================================
  // Timing
  localparam int ACH_CLK_MHZ      = 25;
  localparam int ACH_SETUP_NS     = 80;
  localparam int ACH_STROBE_NS    = 200;
  localparam int ACH_HOLD_NS      = 40;
  localparam int ACH_SETUP_CYC  = (ACH_SETUP_NS * ACH_CLK_MHZ + 999) / 1000;
  localparam int ACH_STROBE_CYC = (ACH_STROBE_NS * ACH_CLK_MHZ + 999) / 1000;
  localparam int ACH_HOLD_CYC   = (ACH_HOLD_NS * ACH_CLK_MHZ + 999) / 1000;
  localparam int ACH_CNT_W      = 4;

  // ==========================================================
  // Reset values
  localparam logic [10:0] ACH_ADDR_RST = 11'h000;
  localparam logic [15:0] ACH_DATA_RST = 16'h0000;
endpackage

/* rtl/ach_sync.sv */
// Purpose: Two flip-flop synchroniser for card status pins
// Assumes: Inputs asynchronous to sys_clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module ach_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } ach_sync_t;

  ach_sync_t state;
  ach_sync_t next_state;

  always_comb begin
    next_state        = state;
    next_state.stage1 = din;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign dout = state.stage2;
endmodule
`default_nettype wire

/* rtl/ach_host.sv */
// Behaviour
// - IDE mode drives A2..A0, grounds A10..A3
// - Selects and A0 choose byte, word, odd
// - Words: even byte D7..D0, odd byte D15..D8; single bytes, even or odd, ride D7..D0
// - Acknowledge ignored outside I/O mode
// - Host grounds ATASEL to pick IDE mode
//
// Purpose: Host side strobe controller for an ATA flash card socket
// Assumes: One access at a time, card pins pass through synchronisers
// Notes:   Strobe lengths are fixed cycle counts, no wait pin handling
`timescale 1ns/100ps
`default_nettype none
module ach_host
  import ach_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic [1:0]   cfgMode,
  input  wire logic         cfgSlave,
  input  wire logic         ioReady,
  input  wire logic         reqValid,
  input  wire logic [1:0]   reqCmd,
  input  wire logic [10:0]  reqAddr,
  input  wire logic         reqByte,
  input  wire logic         reqAlt,
  input  wire logic [15:0]  reqWdata,
  output logic              reqReady,
  output logic              rspValid,
  output logic [15:0]       rspRdata,
  output logic              rspNoAck,
  output logic              cardPresent,
  output logic              batteryOk,
  output logic              statusChange,
  output logic              diagPass,
  output logic              slavePresent,
  output logic [10:0]       cardAddr,
  output logic              cardCe1N,
  output logic              cardCe2N,
  output logic              cardOeN,
  output logic              cardWeN,
  output logic              cardIordN,
  output logic              cardIowrN,
  output logic              cardRegN,
  output logic              cardAtaselN,
  output logic              cardCselOut,
  output logic              cardCselOe,
  output logic [15:0]       cardDataOut,
  output logic              cardDataOe,
  input  wire logic [15:0]  cardDataIn,
  input  wire logic         cardCd1N,
  input  wire logic         cardCd2N,
  input  wire logic         cardInpackN,
  input  wire logic         cardBvd1,
  input  wire logic         cardBvd2,
  output logic              cardPdiagOut,
  output logic              cardPdiagOe,
  output logic              cardDaspOut,
  output logic              cardDaspOe
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } ach_state_t;

  typedef struct packed {
    ach_state_t          fsm;
    logic [ACH_CNT_W-1:0] cnt;
    logic                isRead;
    logic                isAttr;
    logic                ackSeen;
    logic                reqReady;
    logic                rspValid;
    logic [15:0]         rspRdata;
    logic                rspNoAck;
    logic [10:0]         addr;
    logic                ce1N;
    logic                ce2N;
    logic                oeN;
    logic                weN;
    logic                iordN;
    logic                iowrN;
    logic                regN;
    logic                ataselN;
    logic                cselOe;
    logic [15:0]         dOut;
    logic                dOe;
  } ach_host_t;

  ach_host_t state;
  ach_host_t next_state;

  // ==========================================================
  // Pin synchronisers
  logic [15:0] dataSync;
  logic [6:0]  pinSync;

  ach_sync #(.W(16)) u_data_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .din     (cardDataIn),
    .dout    (dataSync)
  );

  ach_sync #(.W(7)) u_pin_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .din     ({cardCd1N, cardCd2N, cardInpackN, cardBvd1, cardBvd2,
               cardBvd1, cardBvd2}),
    .dout    (pinSync)
  );

  // Card address as driven, IDE keeps high bits grounded
  function automatic logic [10:0] pinAddr(input logic [1:0] m,
                                          input logic [10:0] a);
    if (m == ACH_MODE_IDE) begin
      pinAddr = {8'h00, a[2:0]};
    end else begin
      pinAddr = a;
    end
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    next_state          = state;
    next_state.rspValid = 1'b0;
    next_state.ataselN  = (cfgMode != ACH_MODE_IDE);
    next_state.cselOe   = (cfgMode == ACH_MODE_IDE) && !cfgSlave;
    case (state.fsm)
      ST_IDLE: begin
        next_state.reqReady = 1'b1;
        if (reqValid && state.reqReady) begin
          next_state.reqReady = 1'b0;
          next_state.isRead   = (reqCmd == ACH_CMD_READ) ||
                                (reqCmd == ACH_CMD_ATTR_READ);
          next_state.isAttr   = reqCmd[1];
          next_state.ackSeen  = 1'b0;
          next_state.addr     = pinAddr(cfgMode, reqAddr);
          if (cfgMode == ACH_MODE_IDE) begin
            next_state.ce1N = reqAlt;
            next_state.ce2N = !reqAlt;
          end else begin
            // Bytes ride the low lane, A0 picks even or odd
            next_state.ce1N = 1'b0;
            next_state.ce2N = reqByte;
          end
          next_state.regN = (cfgMode == ACH_MODE_IO) ? 1'b0 : !reqCmd[1];
          if (cfgMode == ACH_MODE_IDE) begin
            next_state.regN = 1'b1;
          end
          // Byte sent on low lane when only CE1 selected
          next_state.dOut = (reqByte && cfgMode != ACH_MODE_IDE) ?
                            {reqWdata[7:0], reqWdata[7:0]} : reqWdata;
          next_state.dOe  = !next_state.isRead;
          next_state.cnt  = ACH_CNT_W'(ACH_SETUP_CYC);
          next_state.fsm  = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_state.cnt = state.cnt - 1'b1;
        if (state.cnt == 1) begin
          next_state.cnt = ACH_CNT_W'(ACH_STROBE_CYC);
          next_state.fsm = ST_STROBE;
          // I/O strobes only when the card's I/O side is set up
          if (cfgMode == ACH_MODE_MEM || state.isAttr) begin
            next_state.oeN = !state.isRead;
            next_state.weN = state.isRead;
          end else if (ioReady) begin
            next_state.iordN = !state.isRead;
            next_state.iowrN = state.isRead;
          end
        end
      end
      ST_STROBE: begin
        next_state.cnt = state.cnt - 1'b1;
        if (!pinSync[4] && !state.iordN) begin
          next_state.ackSeen = 1'b1;
        end
        if (state.cnt == 1) begin
          // Byte reads arrive on the low lane already
          next_state.rspRdata = dataSync;
          next_state.oeN   = 1'b1;
          next_state.weN   = 1'b1;
          next_state.iordN = 1'b1;
          next_state.iowrN = 1'b1;
          next_state.cnt   = ACH_CNT_W'(ACH_HOLD_CYC);
          next_state.fsm   = ST_HOLD;
        end
      end
      ST_HOLD: begin
        next_state.cnt = state.cnt - 1'b1;
        if (state.cnt == 1) begin
          next_state.ce1N     = 1'b1;
          next_state.ce2N     = 1'b1;
          next_state.dOe      = 1'b0;
          next_state.rspValid = 1'b1;
          // Acknowledge means nothing outside I/O mode reads
          next_state.rspNoAck = (cfgMode == ACH_MODE_IO) && !state.isAttr &&
                                state.isRead && !state.ackSeen;
          next_state.fsm      = ST_IDLE;
        end
      end
      default: begin
        next_state.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state          <= '0;
      state.fsm      <= ST_IDLE;
      state.addr     <= ACH_ADDR_RST;
      state.dOut     <= ACH_DATA_RST;
      state.ce1N     <= 1'b1;
      state.ce2N     <= 1'b1;
      state.oeN      <= 1'b1;
      state.weN      <= 1'b1;
      state.iordN    <= 1'b1;
      state.iowrN    <= 1'b1;
      state.regN     <= 1'b1;
      state.ataselN  <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Status flops, straight from registers
  logic cardPresentQ;
  logic batteryOkQ;
  logic statusChangeQ;
  logic diagPassQ;
  logic slavePresentQ;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cardPresentQ  <= 1'b0;
      batteryOkQ    <= 1'b0;
      statusChangeQ <= 1'b0;
      diagPassQ     <= 1'b0;
      slavePresentQ <= 1'b0;
    end else begin
      cardPresentQ  <= !pinSync[6] && !pinSync[5];
      batteryOkQ    <= (cfgMode == ACH_MODE_MEM) && pinSync[3] &&
                       pinSync[2];
      statusChangeQ <= (cfgMode == ACH_MODE_IO) && !pinSync[3];
      diagPassQ     <= (cfgMode == ACH_MODE_IDE) && !pinSync[1];
      slavePresentQ <= (cfgMode == ACH_MODE_IDE) &&
                       !pinSync[0];
    end
  end

  assign reqReady     = state.reqReady;
  assign rspValid     = state.rspValid;
  assign rspRdata     = state.rspRdata;
  assign rspNoAck     = state.rspNoAck;
  assign cardPresent  = cardPresentQ;
  assign batteryOk    = batteryOkQ;
  assign statusChange = statusChangeQ;
  assign diagPass     = diagPassQ;
  assign slavePresent = slavePresentQ;
  assign cardAddr     = state.addr;
  assign cardCe1N     = state.ce1N;
  assign cardCe2N     = state.ce2N;
  assign cardOeN      = state.oeN;
  assign cardWeN      = state.weN;
  assign cardIordN    = state.iordN;
  assign cardIowrN    = state.iowrN;
  assign cardRegN     = state.regN;
  assign cardAtaselN  = state.ataselN;
  assign cardCselOut  = 1'b0;
  assign cardCselOe   = state.cselOe;
  assign cardDataOut  = state.dOut;
  assign cardDataOe   = state.dOe;
  // Host only senses the handshake lines
  assign cardPdiagOut = 1'b0;
  assign cardPdiagOe  = 1'b0;
  assign cardDaspOut  = 1'b0;
  assign cardDaspOe   = 1'b0;

  // ==========================================================
  // Checks
  a_ide_high_addr: assert property (@(posedge sys_clk) disable iff (srst)
    (cfgMode == ACH_MODE_IDE && state.fsm == ST_STROBE) |->
    cardAddr[10:3] == 8'h00) else $error("IDE high address not grounded");
  a_strobe_width: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(cardOeN) |-> !cardOeN [*5]) else $error("OE strobe too short");
  a_one_strobe: assert property (@(posedge sys_clk) disable iff (srst)
    !(!cardOeN && !cardIordN)) else $error("OE and IORD both low");
  a_io_gate: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(cardIordN) |-> $past(ioReady)) else $error("IORD before set up");
  a_word_select: assert property (@(posedge sys_clk) disable iff (srst)
    (($fell(cardOeN) || $fell(cardIordN)) && cfgMode != ACH_MODE_IDE) |->
    !cardCe1N)
    else $error("Strobe without select");
  a_ide_alt_sel: assert property (@(posedge sys_clk) disable iff (srst)
    (cfgMode == ACH_MODE_IDE && state.fsm == ST_STROBE) |->
    (cardCe1N != cardCe2N)) else $error("IDE select not exclusive");
  a_csel_drive: assert property (@(posedge sys_clk) disable iff (srst)
    ##1 (cardCselOe == $past(cfgMode == ACH_MODE_IDE && !cfgSlave)))
    else $error("CSEL drive wrong");
  a_rsp_after: assert property (@(posedge sys_clk) disable iff (srst)
    (reqValid && reqReady) |-> ##9 rspValid)
    else $error("Answer late");
  a_data_idle: assert property (@(posedge sys_clk) disable iff (srst)
    (state.fsm == ST_IDLE && !rspValid && !(reqValid && reqReady)) |=>
    !cardDataOe || state.fsm != ST_IDLE) else $error("Bus driven idle");

  c_mem_read: cover property (@(posedge sys_clk) $fell(cardOeN));
  c_io_read: cover property (@(posedge sys_clk) $fell(cardIordN));
  c_write: cover property (@(posedge sys_clk) $fell(cardWeN));
  c_no_ack: cover property (@(posedge sys_clk) rspValid && rspNoAck);
endmodule
`default_nettype wire

/* verif/ach_card_model.sv */
// Purpose: Behavioural card on the far side of the host pin controller
// Assumes: Personality from cfgMode, IDE picked by the ATASEL pin
// Notes:   Released data lanes carry a pattern that moves every cycle
`timescale 1ns/100ps
`default_nettype none
module ach_card_model
  import ach_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [1:0]  cfgMode,
  input  wire logic        ioReady,
  input  wire logic        evt,
  input  wire logic [10:0] cardAddr,
  input  wire logic        cardCe1N,
  input  wire logic        cardCe2N,
  input  wire logic        cardOeN,
  input  wire logic        cardWeN,
  input  wire logic        cardIordN,
  input  wire logic        cardIowrN,
  input  wire logic        cardRegN,
  input  wire logic        cardAtaselN,
  input  wire logic        cselN,
  input  wire logic [15:0] cardDataIn,
  output logic [15:0]      dataDrv,
  output logic             cardInpackN,
  output logic             cardCd1N,
  output logic             cardCd2N,
  output logic             bvdPin1,
  output logic             bvdPin2,
  output logic             isSlave
);
  // ==========
  // Storage
  logic [7:0]  mem [0:4095];
  logic [15:0] ideReg [0:15];
  logic [15:0] scr = 16'h1d2b;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic        ide;
  logic        ioMode;
  logic        ioOk;
  logic        attr;
  logic        rdOn;
  logic [11:0] bx;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (ideReg[i]) ideReg[i] = 16'h0000;
  end
  // ==========
  // Decode
  assign ide    = !cardAtaselN;
  assign ioMode = !ide && cfgMode == ACH_MODE_IO;
  assign ioOk   = ioReady && (ide || ioMode);
  assign attr   = !cardRegN && cardIordN && cardIowrN;
  assign bx     = {attr, cardAddr[10:1], cardCe2N ? cardAddr[0] : 1'b0};
  assign rdOn   = (!cardOeN && !ide) || (!cardIordN && ioOk);
  assign lo     = mem[bx];
  assign hi     = mem[{attr, cardAddr[10:1], 1'b1}];
  // Stale data on a released bus would hide a late sample
  always @(posedge sys_clk) scr <= ~{scr[14:0], scr[15]};
  always_comb begin
    dataDrv = scr;
    if (rdOn && ide) begin
      dataDrv = ideReg[{!cardCe2N, cardAddr[2:0]}];
    end else if (rdOn) begin
      dataDrv = {cardCe2N ? scr[15:8] : hi, cardCe1N ? scr[7:0] : lo};
    end
  end
  assign cardInpackN = !(ioMode && ioOk && !cardIordN && !(cardCe1N && cardCe2N));
  assign cardCd1N = 1'b0;
  assign cardCd2N = 1'b0;
  assign bvdPin1  = (ide || ioMode) ? !evt : 1'b1;
  assign bvdPin2  = ide ? !evt : 1'b1;
  assign isSlave  = cselN;
  // ==========
  // Writes land on the trailing edge of the strobe
  task automatic put(input logic at);
    if (ide) begin
      ideReg[{!cardCe2N, cardAddr[2:0]}] = cardDataIn;
    end else begin
      if (!cardCe1N) mem[{at, cardAddr[10:1], cardCe2N ? cardAddr[0] : 1'b0}] = cardDataIn[7:0];
      if (!cardCe2N) mem[{at, cardAddr[10:1], 1'b1}] = cardDataIn[15:8];
    end
  endtask
  always @(posedge cardWeN) if (!ide) put(!cardRegN);
  always @(posedge cardIowrN) if (ioOk) put(1'b0);
endmodule
`default_nettype wire

/* verif/ach_host_bench.sv */
// Purpose: Self-checking bench for the card host pin controller
// Assumes: Card model on the far side, xorshift stimulus, fixed seed
// Notes:   Upper byte of a byte read is not compared
`timescale 1ns/100ps
`default_nettype none
module ach_host_bench
  import ach_pkg::*;
;
  // ==========
  // Signals
  logic        sys_clk  = 1'b0;
  logic        srst     = 1'b1;
  logic [1:0]  cfgMode  = 2'h0;
  logic        cfgSlave = 1'b0;
  logic        ioReady  = 1'b1;
  logic        evt      = 1'b0;
  logic        reqValid = 1'b0;
  logic [1:0]  reqCmd   = 2'h0;
  logic [10:0] reqAddr  = 11'h000;
  logic        reqByte  = 1'b0;
  logic        reqAlt   = 1'b0;
  logic [15:0] reqWdata = 16'h0000;
  logic        reqReady, rspValid, rspNoAck, cardPresent, batteryOk;
  logic        statusChange, diagPass, slavePresent, cardCe1N, cardCe2N;
  logic        cardOeN, cardWeN, cardIordN, cardIowrN, cardRegN;
  logic        cardAtaselN, cardCselOut, cardCselOe, cardDataOe;
  logic        cardInpackN, cardCd1N, cardCd2N, cardPdiagOut, cardPdiagOe;
  logic        cardDaspOut, cardDaspOe, bvdPin1, bvdPin2, isSlave;
  logic [10:0] cardAddr;
  logic [15:0] rspRdata, cardDataOut, dataDrv;
  logic [7:0]  sh [0:4095];
  logic [15:0] ideSh [0:15];
  logic [31:0] seed = 32'h4cb4e0e7;
  logic [31:0] r;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // Open CSEL floats high through the socket pull-up
  wire logic [15:0] cardDataIn = cardDataOe ? cardDataOut : dataDrv;
  wire logic        cselN      = cardCselOe ? cardCselOut : 1'b1;
  wire logic        cardBvd1   = cardPdiagOe ? cardPdiagOut : bvdPin1;
  wire logic        cardBvd2   = cardDaspOe ? cardDaspOut : bvdPin2;

  ach_host i_dut (.*);
  ach_card_model i_card (.*);

  always #20 sys_clk = ~sys_clk;
  // ==========
  // Helpers
  task automatic finish_test();
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] exp_rd(input logic at, input logic [10:0] a,
                                         input logic al);
    if (cfgMode == ACH_MODE_IDE) return ideSh[{al, a[2:0]}];
    return {sh[{at, a[10:1], 1'b1}], sh[{at, a}]};
  endfunction
  // ==========
  // One access, shadow kept beside it
  task automatic op(input logic [1:0] c, input logic [10:0] a, input logic b,
                    input logic al);
    logic [15:0] w;
    logic [15:0] m;
    logic        ok;
    int          n;
    w = rnd();
    if (b) w = {w[7:0], w[7:0]};
    if (!b && cfgMode != ACH_MODE_IDE) a[0] = 1'b0;
    ok = cfgMode == ACH_MODE_MEM || c[1] || ioReady;
    m = b ? 16'h00ff : 16'hffff;
    reqCmd = c;
    reqAddr = a;
    reqByte = b;
    reqAlt = al;
    reqWdata = w;
    n = 0;
    while (reqReady !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    reqValid = 1'b1;
    @(posedge sys_clk);
    #2 reqValid = 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #2 n++;
    end while (rspValid !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      finish_test();
    end
    if (!c[0] && ok) check("rdData", exp_rd(c[1], a, al) & m, rspRdata & m);
    if (!c[0] && !c[1]) check("noAck", {15'h0000, cfgMode == ACH_MODE_IO && !ioReady}, {15'h0000, rspNoAck});
    if (c[0] && ok && cfgMode == ACH_MODE_IDE) ideSh[{al, a[2:0]}] = w;
    else if (c[0] && ok && b) sh[{c[1], a}] = w[7:0];
    else if (c[0] && ok) begin
      sh[{c[1], a}] = w[7:0];
      sh[{c[1], a[10:1], 1'b1}] = w[15:8];
    end
  endtask
  // ==========
  // Wire watch and timeout
  always @(posedge sys_clk) begin
    cycles++;
    if (!srst && cfgMode == ACH_MODE_IDE && !(cardCe1N && cardCe2N))
      check("highAddr", 16'h0000, {8'h00, cardAddr[10:3]});
    if (!srst && cfgMode == ACH_MODE_MEM)
      check("iordIdle", 16'h0001, {15'h0000, cardIordN});
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  // ==========
  // Main sequence
  initial begin
    foreach (sh[i]) sh[i] = 8'h00;
    foreach (ideSh[i]) ideSh[i] = 16'h0000;
    tick(3);
    srst = 1'b0;
    for (int k = 0; k < 3; k++) begin
      cfgMode = 2'(k);
      for (int j = 0; j < 2; j++) begin
        evt = ~evt;
        cfgSlave = ~cfgSlave;
        tick(8);
        check("present", 16'h0001, {15'h0000, cardPresent});
        if (k == 0) check("battery", 16'h0001, {15'h0000, batteryOk});
        if (k == 1) check("stsChg", {15'h0000, evt}, {15'h0000, statusChange});
        if (k == 2) check("slaveCfg", {15'h0000, cfgSlave}, {15'h0000, isSlave});
        if (k == 2) check("diag", {15'h0000, evt}, {15'h0000, diagPass});
        if (k == 2) check("dasp", {15'h0000, evt}, {15'h0000, slavePresent});
      end
      // Top end of the address range first, then random mix
      op(2'h1, 11'h7fe, 1'b0, 1'b0);
      op(2'h0, 11'h7ff, k != 2, 1'b1);
      for (int j = 0; j < 40; j++) begin
        r = rnd();
        ioReady = |r[1:0];
        reqAddr = r[8] ? r[20:10] : {{7{r[9]}}, r[13:10]};
        op({k != 2 && r[4], 1'b1}, reqAddr, k != 2 && r[6], r[7]);
        op({k != 2 && r[4], 1'b0}, reqAddr, k != 2 && r[5], r[7]);
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
